// ### verilog/cdrg_top.sv
// Register bank, readback multiplexer, gain map and phase generation of the image digitizer.
`timescale 1ns/1ps
`default_nettype none
module cdrg_top
   import cdrg_pkg::*;
#(
   parameter int DATA_W     = 12,
   parameter int FIFO_DEPTH = 8
) (
   // Clock and reset
   input  wire logic              clk_sys,
   input  wire logic              sys_rst,
   input  wire logic              chip_reset_pin,
   // Register write port
   input  wire logic              reg_wr,
   input  wire logic [5:0]        reg_addr,
   input  wire logic [9:0]        reg_wdata,
   // Other serial registers shown on readback, addresses 0 to 12 except 8, which reads the control register
   input  wire logic [9:0]        serial_regs [13],
   // Calibration logic values
   input  wire logic [9:0]        fine_offset_code,
   input  wire logic [8:0]        coarse_offset_code,
   input  wire logic [9:0]        black_average,
   input  wire logic [9:0]        gain_code,
   // Sample clocks, already synchronous, as levels
   input  wire logic              black_sample_clock,
   input  wire logic              pixel_sample_clock,
   input  wire logic              conversion_clock,
   input  wire logic              clamp,
   input  wire logic              reset_reject_clocked,
   // Converter samples
   input  wire logic              adc_valid,
   output logic                   adc_ready,
   input  wire logic [DATA_W-1:0] adc_data,
   // Calibration sample feed
   output logic                   cal_valid,
   input  wire logic              cal_ready,
   output logic      [DATA_W-1:0] cal_data,
   // Output bus
   output logic      [DATA_W-1:0] digital_output_bus,
   // Analog steering and codes
   output logic      [7:0]        utility_converter_0,
   output logic      [7:0]        utility_converter_1,
   output logic                   cds_bypass,
   output logic                   sel_test_inputs,
   output logic                   coarse_offset_apply,
   output logic                   fine_offset_apply,
   output logic                   phase_black,
   output logic                   phase_pixel,
   output logic                   phase_reset_reject,
   output logic                   dc_restore,
   output logic      [11:0]       gain_db_x100,
   output logic      [3:0]        gain_doublings,
   output logic                   chip_reset_active
);
   localparam logic [2:0] RST_CNT_INIT = 3'(SOFT_RESET_CYCLES);

   logic [7:0]  util0;
   logic [7:0]  util1;
   logic [9:0]  readback_ctl;
   logic [9:0]  control;
   logic        soft_reset;
   logic [2:0]  soft_cnt;
   logic        chip_rst;
   logic        conv_prev;
   logic        conv_edge;
   cdrg_out_t   out_mode;
   logic [9:0]  rb_value;
   logic [9:0]  next_rb_value;
   logic        fifo_valid;
   logic [DATA_W-1:0] fifo_data;

   // Whole-chip reset from the async reset, the pin or the self-clearing bit.
   assign chip_rst          = sys_rst || chip_reset_pin || soft_reset;
   assign chip_reset_active = chip_rst;

   // Serial register value by address; unmapped addresses read zero.
   function automatic logic [9:0] serial_value(input logic [5:0] a);
      if (a == ADDR_CONTROL) begin
         serial_value = control;
      end else if (a <= 6'h0c) begin
         serial_value = serial_regs[a[3:0]];
      end else if (a == ADDR_UTIL0_CODE) begin
         serial_value = {2'h0, util0};
      end else if (a == ADDR_UTIL1_CODE) begin
         serial_value = {2'h0, util1};
      end else if (a == ADDR_READBACK) begin
         serial_value = readback_ctl;
      end else if (a == ADDR_CHIP_RESET) begin
         serial_value = {9'h000, soft_reset};
      end else begin
         serial_value = 10'h000;
      end
   endfunction : serial_value

   // ==========================================================
   // Register writes. The control bank is held in reset by every chip reset source.
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         util0        <= UTIL_RESET[7:0];
         util1        <= UTIL_RESET[7:0];
         readback_ctl <= READBACK_RESET;
         control      <= CONTROL_RESET;
      end else if (chip_reset_pin || soft_reset) begin
         util0        <= UTIL_RESET[7:0];
         util1        <= UTIL_RESET[7:0];
         readback_ctl <= READBACK_RESET;
         control      <= CONTROL_RESET;
      end else if (reg_wr) begin
         case (reg_addr)
            ADDR_UTIL0_CODE: begin
               util0 <= reg_wdata[UTIL_W-1:0];
            end
            ADDR_UTIL1_CODE: begin
               util1 <= reg_wdata[UTIL_W-1:0];
            end
            ADDR_READBACK: begin
               readback_ctl <= reg_wdata;
            end
            ADDR_CONTROL: begin
               control <= reg_wdata;
            end
            default: begin
               util0 <= util0;
            end
         endcase
      end
   end

   // Self-clearing reset bit; held for the derived count of cycles.
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         soft_reset <= 1'b0;
         soft_cnt   <= 3'h0;
      end else if (soft_reset) begin
         soft_cnt   <= soft_cnt - 3'h1;
         soft_reset <= (soft_cnt != 3'h1);
      end else if (reg_wr && reg_addr == ADDR_CHIP_RESET && reg_wdata[CHIP_RESET_BIT]) begin
         soft_reset <= 1'b1;
         soft_cnt   <= RST_CNT_INIT;
      end
   end

   // Utility codes pass straight through; code 0 is lowest level, all ones highest.
   assign utility_converter_0 = util0;
   assign utility_converter_1 = util1;

   // ==========================================================
   // Bypass steering: coarse offset drops out, fine offset stays.
   assign cds_bypass          = control[CDS_BYPASS_BIT];
   assign sel_test_inputs     = cds_bypass;
   assign coarse_offset_apply = !cds_bypass;
   assign fine_offset_apply   = 1'b1;

   // Phases follow the sample clocks; reset reject is always on unless clocked.
   assign phase_black        = black_sample_clock;
   assign phase_pixel        = pixel_sample_clock;
   assign phase_reset_reject = reset_reject_clocked ? pixel_sample_clock : 1'b1;
   assign dc_restore         = clamp && phase_pixel;

   // ==========================================================
   // Gain map in hundredths of a dB; codes past the knee are clamped to 36 dB.
   // The product is kept wide so the exact code/768 ratio is used, not a rounded step.
   always_comb begin
      logic [9:0]  code;
      logic [21:0] prod;
      code = 10'h000;
      prod = 22'h000000;
      code = (gain_code >= GAIN_CODE_MAX) ? GAIN_CODE_MAX : gain_code;
      prod = 22'(code) * 22'(GAIN_MAX_DB * 100);
      gain_db_x100   = 12'(prod / 22'(GAIN_CODE_MAX));
      gain_doublings = 4'(code / 10'(GAIN_DOUBLE_STEP));
   end

   // ==========================================================
   // Readback value selection from the select field.
   always_comb begin
      next_rb_value = 10'h000;
      case (readback_ctl[8:6])
         CAL_SEL_NONE: begin
            next_rb_value = serial_value(readback_ctl[5:0]);
         end
         CAL_SEL_FINE: begin
            next_rb_value = fine_offset_code;
         end
         CAL_SEL_COARSE: begin
            next_rb_value = {1'b0, coarse_offset_code};
         end
         CAL_SEL_AVG: begin
            next_rb_value = black_average;
         end
         default: begin
            next_rb_value = 10'h000;
         end
      endcase
   end

   // Conversion clock rising edge marks a word boundary.
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         conv_prev <= 1'b0;
      end else begin
         conv_prev <= conversion_clock;
      end
   end
   assign conv_edge = conversion_clock && !conv_prev;

   // Mode and value change only at a boundary, so a word is never half mixed.
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         out_mode <= CDRG_OUT_ADC;
         rb_value <= 10'h000;
      end else if (conv_edge) begin
         out_mode <= readback_ctl[RB_ENABLE_BIT] ? CDRG_OUT_REG : CDRG_OUT_ADC;
         rb_value <= next_rb_value;
      end
   end

   // ==========================================================
   // Samples buffer ahead of calibration; a stalled consumer pushes back on the source.
   cdrg_fifo #(
      .WIDTH (DATA_W),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .clk_sys   (clk_sys),
      .sys_rst   (sys_rst),
      .in_valid  (adc_valid),
      .in_ready  (adc_ready),
      .in_data   (adc_data),
      .out_valid (fifo_valid),
      .out_ready (cal_ready),
      .out_data  (fifo_data)
   );
   // Samples go to calibration in both output modes.
   assign cal_valid = fifo_valid;
   assign cal_data  = fifo_data;

   // Output bus register: converter data or the readback word in the top ten bits.
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         digital_output_bus <= '0;
      end else if (adc_valid && adc_ready) begin
         case (out_mode)
            CDRG_OUT_REG: begin
               digital_output_bus <= {rb_value, 2'h0};
            end
            CDRG_OUT_ADC: begin
               digital_output_bus <= adc_data;
            end
            default: begin
               digital_output_bus <= adc_data;
            end
         endcase
      end
   end

   // ==========================================================
   // Checks.
   soft_reset_len_a : assert property (@(posedge clk_sys) disable iff (sys_rst)
      $rose(soft_reset) |-> soft_reset [*1] ##1 !soft_reset)
      else $error("soft reset length wrong");
   restore_gate_a : assert property (@(posedge clk_sys) disable iff (sys_rst)
      dc_restore |-> clamp && pixel_sample_clock)
      else $error("dc restore without clamp and pixel phase");
   bypass_coarse_a : assert property (@(posedge clk_sys) disable iff (sys_rst)
      cds_bypass |-> !coarse_offset_apply && fine_offset_apply && sel_test_inputs)
      else $error("bypass steering wrong");
   gain_clamp_a : assert property (@(posedge clk_sys) disable iff (sys_rst)
      gain_code >= GAIN_CODE_MAX |-> gain_db_x100 == 12'he10 && gain_doublings == 4'h6)
      else $error("gain not clamped");
   mode_change_a : assert property (@(posedge clk_sys) disable iff (sys_rst)
      out_mode != $past(out_mode) |-> $past(conv_edge))
      else $error("output mode changed off boundary");
   readback_bus_a : assert property (@(posedge clk_sys) disable iff (sys_rst)
      adc_valid && adc_ready && out_mode == CDRG_OUT_REG |=> digital_output_bus == {$past(rb_value), 2'h0})
      else $error("readback word not on bus");
   adc_bus_a : assert property (@(posedge clk_sys) disable iff (sys_rst)
      adc_valid && adc_ready && out_mode == CDRG_OUT_ADC |=> digital_output_bus == $past(adc_data))
      else $error("converter data not on bus");
   cal_select_a : assert property (@(posedge clk_sys) disable iff (sys_rst)
      readback_ctl[8:6] > CAL_SEL_AVG |-> next_rb_value == 10'h000)
      else $error("undefined code not zero");
   pin_reset_a : assert property (@(posedge clk_sys) disable iff (sys_rst)
      chip_reset_pin |=> readback_ctl == READBACK_RESET && !cds_bypass)
      else $error("pin reset did not clear registers");
   cal_feed_a : assert property (@(posedge clk_sys) disable iff (sys_rst)
      fifo_valid |-> cal_valid && cal_data == fifo_data)
      else $error("calibration feed dropped");
endmodule : cdrg_top
`default_nettype wire

// ### verilog/cdrg_pkg.sv
// Package of register offsets, field positions, reset values and timing for the digitizer register side.
package cdrg_pkg;
   // ==========================================================
   // Register addresses (6-bit serial register space)
   localparam logic [5:0] ADDR_UTIL0_CODE  = 6'h0d;
   localparam logic [5:0] ADDR_UTIL1_CODE  = 6'h0e;
   localparam logic [5:0] ADDR_CONTROL     = 6'h08;
   localparam logic [5:0] ADDR_READBACK    = 6'h3e;
   localparam logic [5:0] ADDR_CHIP_RESET  = 6'h3f;
   localparam logic [5:0] ADDR_LAST_PLAIN  = 6'h0e;
   // ==========================================================
   // Field positions
   localparam int RB_ENABLE_BIT     = 9;
   localparam int CDS_BYPASS_BIT    = 7;
   localparam int CHIP_RESET_BIT    = 0;
   localparam int REG_W             = 10;
   localparam int UTIL_W            = 8;
   // ==========================================================
   // Reset values
   localparam logic [9:0] UTIL_RESET     = 10'h000;
   localparam logic [9:0] READBACK_RESET = 10'h000;
   localparam logic [9:0] CONTROL_RESET  = 10'h038;
   // ==========================================================
   // Calibration selector codes in the upper three select bits
   localparam logic [2:0] CAL_SEL_NONE   = 3'h0;
   localparam logic [2:0] CAL_SEL_FINE   = 3'h1;
   localparam logic [2:0] CAL_SEL_COARSE = 3'h2;
   localparam logic [2:0] CAL_SEL_AVG    = 3'h3;
   // ==========================================================
   // Gain mapping
   localparam logic [9:0] GAIN_CODE_MAX  = 10'h300;
   localparam int         GAIN_MAX_DB    = 36;
   localparam int         GAIN_DOUBLE_STEP = 128;
   // ==========================================================
   // Timing
   localparam int CLK_PERIOD_PS     = 8000;
   localparam int SOFT_RESET_PS     = 10000;
   localparam int SOFT_RESET_CYCLES = (SOFT_RESET_PS / CLK_PERIOD_PS) < 1 ? 1 : (SOFT_RESET_PS / CLK_PERIOD_PS);
   // ==========================================================
   // Readback multiplexer states
   typedef enum logic [0:0] {
      CDRG_OUT_ADC  = 1'b0,
      CDRG_OUT_REG  = 1'b1
   } cdrg_out_t;
endpackage : cdrg_pkg

// ### verilog/cdrg_fifo.sv
// Small synchronous FIFO with valid/ready on both sides.
`timescale 1ns/1ps
`default_nettype none
module cdrg_fifo
   import cdrg_pkg::*;
#(
   parameter int WIDTH = 12,
   parameter int DEPTH = 8
) (
   // Clock and reset
   input  wire logic             clk_sys,
   input  wire logic             sys_rst,
   // Fill side
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   // Drain side
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic      [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]    wr_ptr;
   logic [AW-1:0]    rd_ptr;
   logic [AW:0]      count;
   logic             push;
   logic             pop;

   // Full and empty come straight from the occupancy count.
   assign in_ready  = (count != (AW+1)'(DEPTH));
   assign out_valid = (count != '0);
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;
   assign out_data  = mem[rd_ptr];

   // ==========================================================
   // Storage has no reset so it maps to plain RAM.
   always_ff @(posedge clk_sys) begin
      if (push) begin
         mem[wr_ptr] <= in_data;
      end
   end

   // Pointers and count.
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count  <= '0;
      end else begin
         if (push) begin
            wr_ptr <= (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
         end
         if (pop) begin
            rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
         end
         count <= count + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
endmodule : cdrg_fifo
`default_nettype wire

// ### sim/cdrg_camera_model.sv
// Model of the camera timing generator and signal processor facing the digitizer.
`timescale 1ns/1ps
`default_nettype none
module cdrg_camera_model (
   // Clock and reset
   input  wire logic        clk_sys,
   input  wire logic        sys_rst,
   // Control from the bench
   input  wire logic        run,
   input  wire logic        stall,
   input  wire logic [11:0] word,
   // Pixel rate clocks
   output logic             black_sample_clock,
   output logic             pixel_sample_clock,
   output logic             conversion_clock,
   // Sample stream and calibration feed
   output logic             adc_valid,
   output logic      [11:0] adc_data,
   output logic             cal_ready
);
   // ==========================================================
   // Pixel timing
   logic [1:0] phase;

   // A four-cycle pixel period that never pauses, so bypass mode still sees live clocks.
   always @(negedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         phase <= 2'h0;
      end else begin
         phase <= phase + 2'h1;
      end
   end

   // Black and pixel sampling sit in separate quarters of the period.
   assign black_sample_clock = (phase == 2'h0);
   assign pixel_sample_clock = (phase == 2'h2);
   assign conversion_clock   = phase[1];
   // ==========================================================
   // Sample stream
   // Data is inverted while not offered, so a stale word is never mistaken for a fresh one.
   assign adc_valid = run;
   assign adc_data  = run ? word : ~word;
   assign cal_ready = !stall;
endmodule : cdrg_camera_model
`default_nettype wire

// ### sim/testbench.sv
// Self-checking testbench of the digitizer register side.
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import cdrg_pkg::*;
   // ==========================================================
   // Signals
   logic        clk_sys, sys_rst, chip_reset_pin, reg_wr, clamp, reset_reject_clocked;
   logic [5:0]  reg_addr;
   logic [9:0]  reg_wdata, fine_offset_code, black_average, gain_code;
   logic [8:0]  coarse_offset_code;
   logic [9:0]  serial_regs [13];
   logic        black_sample_clock, pixel_sample_clock, conversion_clock;
   logic        adc_valid, adc_ready, cal_valid, cal_ready, run, stall;
   logic [11:0] adc_data, cal_data, digital_output_bus, word;
   logic [7:0]  utility_converter_0, utility_converter_1;
   logic        cds_bypass, sel_test_inputs, coarse_offset_apply, fine_offset_apply;
   logic        phase_black, phase_pixel, phase_reset_reject, dc_restore, chip_reset_active;
   logic [11:0] gain_db_x100;
   logic [3:0]  gain_doublings;
   int          bad_count, n_tests;

   cdrg_top #(.DATA_W(12), .FIFO_DEPTH(8)) DUT (
      .clk_sys(clk_sys), .sys_rst(sys_rst), .chip_reset_pin(chip_reset_pin), .reg_wr(reg_wr),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .serial_regs(serial_regs),
      .fine_offset_code(fine_offset_code), .coarse_offset_code(coarse_offset_code),
      .black_average(black_average), .gain_code(gain_code), .black_sample_clock(black_sample_clock),
      .pixel_sample_clock(pixel_sample_clock), .conversion_clock(conversion_clock), .clamp(clamp),
      .reset_reject_clocked(reset_reject_clocked), .adc_valid(adc_valid), .adc_ready(adc_ready),
      .adc_data(adc_data), .cal_valid(cal_valid), .cal_ready(cal_ready), .cal_data(cal_data),
      .digital_output_bus(digital_output_bus), .utility_converter_0(utility_converter_0),
      .utility_converter_1(utility_converter_1), .cds_bypass(cds_bypass), .sel_test_inputs(sel_test_inputs),
      .coarse_offset_apply(coarse_offset_apply), .fine_offset_apply(fine_offset_apply),
      .phase_black(phase_black), .phase_pixel(phase_pixel), .phase_reset_reject(phase_reset_reject),
      .dc_restore(dc_restore), .gain_db_x100(gain_db_x100), .gain_doublings(gain_doublings),
      .chip_reset_active(chip_reset_active));

   cdrg_camera_model camera (
      .clk_sys(clk_sys), .sys_rst(sys_rst), .run(run), .stall(stall), .word(word),
      .black_sample_clock(black_sample_clock), .pixel_sample_clock(pixel_sample_clock),
      .conversion_clock(conversion_clock), .adc_valid(adc_valid), .adc_data(adc_data),
      .cal_ready(cal_ready));

   // Clock of 8 ns.
   initial begin
      clk_sys = 1'b0;
      forever #4 clk_sys = ~clk_sys;
   end
   // ==========================================================
   // Shared tasks
   task automatic chk(input string name, input logic [11:0] exp, input logic [11:0] got);
      n_tests++;
      if (got !== exp) begin
         $display("FAIL %s expected %h seen %h", name, exp, got);
         bad_count++;
      end
   endtask : chk

   // One-cycle write strobe; the leading wait keeps back-to-back calls a cycle apart.
   task automatic wr(input logic [5:0] a, input logic [9:0] d);
      @(negedge clk_sys);
      reg_wr = 1'b1;
      reg_addr = a;
      reg_wdata = d;
      @(negedge clk_sys);
      reg_wr = 1'b0;
   endtask : wr

   // Readback needs a conversion clock rise and an accepted sample, both within a period.
   task automatic rb(input logic [8:0] sel, input logic [9:0] exp);
      wr(ADDR_READBACK, {1'b1, sel});
      repeat (12) @(negedge clk_sys);
      chk("readback bus", {exp, 2'b00}, digital_output_bus);
   endtask : rb

   task automatic stop_test;
      if (bad_count == 0 && n_tests > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : stop_test
   // ==========================================================
   // Scenarios
   task automatic t_util;
      chk("util0 reset", 12'h000, utility_converter_0);
      chk("bypass reset", 12'h000, cds_bypass);
      wr(ADDR_UTIL1_CODE, 10'h3ff);
      wr(ADDR_UTIL0_CODE, 10'h3ff);
      chk("util1 max", 12'h0ff, utility_converter_1);
      chk("util0 max", 12'h0ff, utility_converter_0);
      wr(ADDR_UTIL0_CODE, 10'h000);
      chk("util0 min", 12'h000, utility_converter_0);
   endtask : t_util

   task automatic t_bypass;
      wr(ADDR_CONTROL, 10'h0b8);
      chk("bypass on", 12'h001, {cds_bypass, sel_test_inputs} == 2'b11);
      chk("coarse off", 12'h000, coarse_offset_apply);
      chk("fine on", 12'h001, fine_offset_apply);
      wr(ADDR_CONTROL, 10'h038);
      chk("bypass off", 12'h000, sel_test_inputs);
   endtask : t_bypass

   task automatic t_readback;
      wr(ADDR_UTIL0_CODE, 10'h0a5);
      wr(ADDR_READBACK, 10'h00d);
      repeat (12) @(negedge clk_sys);
      chk("bus adc data", word, digital_output_bus);
      rb(9'h00d, 10'h0a5);
      rb(9'h005, serial_regs[5]);
      rb(9'h008, 10'h038);
      rb(9'h00e, 10'h3ff & 10'h0ff);
      rb(9'h03e, 10'h23e);
      rb(9'h03f, 10'h000);
      rb(9'h07f, fine_offset_code);
      rb(9'h0bf, {1'b0, coarse_offset_code});
      rb(9'h0c0, black_average);
      rb(9'h014, 10'h000);
      rb(9'h140, 10'h000);
   endtask : t_readback

   // Readback stays enabled so the calibration feed is proven to run beside it.
   task automatic t_fifo;
      int n;
      n = 0;
      stall = 1'b1;
      repeat (20) @(negedge clk_sys);
      chk("fifo full", 12'h000, adc_ready);
      run = 1'b0;
      stall = 1'b0;
      chk("cal head", word, cal_data);
      repeat (12) begin
         if (cal_valid === 1'b1) n++;
         @(negedge clk_sys);
      end
      chk("cal count", 12'd8, n[11:0]);
      run = 1'b1;
      wr(ADDR_READBACK, 10'h000);
   endtask : t_fifo

   task automatic t_gain;
      logic [9:0] codes [6];
      logic [3:0] dbl [6];
      logic [11:0] db [6];
      codes = '{10'd0, 10'd127, 10'd128, 10'd767, 10'd768, 10'd1023};
      dbl = '{4'd0, 4'd0, 4'd1, 4'd5, 4'd6, 4'd6};
      db = '{12'd0, 12'd595, 12'd600, 12'd3595, 12'd3600, 12'd3600};
      for (int i = 0; i < 6; i++) begin
         @(negedge clk_sys);
         gain_code = codes[i];
         #1;
         chk("gain doublings", dbl[i], gain_doublings);
         chk("gain db", db[i], gain_db_x100);
      end
   endtask : t_gain

   task automatic t_phase;
      @(negedge clk_sys);
      clamp = 1'b1;
      reset_reject_clocked = 1'b1;
      repeat (8) begin
         @(posedge clk_sys);
         #1;
         chk("black phase", black_sample_clock, phase_black);
         chk("reject phase", pixel_sample_clock, phase_reset_reject);
         chk("dc restore", pixel_sample_clock, dc_restore);
      end
      @(negedge clk_sys);
      clamp = 1'b0;
      reset_reject_clocked = 1'b0;
      repeat (4) begin
         @(posedge clk_sys);
         #1;
         chk("restore idle", 12'h000, dc_restore);
         chk("reject fixed", 12'h001, phase_reset_reject);
         chk("pixel phase", pixel_sample_clock, phase_pixel);
      end
   endtask : t_phase

   task automatic t_resets;
      logic seen;
      seen = 1'b0;
      wr(ADDR_UTIL0_CODE, 10'h055);
      wr(ADDR_CHIP_RESET, 10'h001);
      repeat (3) begin
         if (chip_reset_active === 1'b1) seen = 1'b1;
         @(negedge clk_sys);
      end
      chk("soft reset seen", 12'h001, seen);
      chk("soft reset clear", 12'h000, chip_reset_active);
      chk("util0 cleared", 12'h000, utility_converter_0);
      wr(ADDR_UTIL1_CODE, 10'h0aa);
      @(negedge clk_sys);
      chip_reset_pin = 1'b1;
      repeat (3) @(negedge clk_sys);
      chk("pin reset", 12'h001, chip_reset_active);
      chk("util1 cleared", 12'h000, utility_converter_1);
      chip_reset_pin = 1'b0;
      wr(ADDR_UTIL1_CODE, 10'h033);
      chk("after pin", 12'h033, utility_converter_1);
   endtask : t_resets
   // ==========================================================
   // Main sequence
   initial begin
      bad_count = 0;
      n_tests = 0;
      sys_rst = 1'b1;
      {chip_reset_pin, reg_wr, clamp, reset_reject_clocked, stall} = 5'h00;
      reg_addr = 6'h00;
      reg_wdata = 10'h000;
      gain_code = 10'h000;
      // Calibration values stay fixed, as a held calibration would keep them during bypass.
      fine_offset_code = 10'h2c3;
      coarse_offset_code = 9'h15a;
      black_average = 10'h1e7;
      word = 12'h9a6;
      run = 1'b1;
      for (int i = 0; i < 13; i++) serial_regs[i] = 10'h100 + 10'(i);
      repeat (8) @(negedge clk_sys);
      sys_rst = 1'b0;
      t_util();
      t_bypass();
      t_readback();
      t_fifo();
      t_gain();
      t_phase();
      t_resets();
      stop_test();
   end

   // The sequence needs about 260 cycles; twenty thousand means a hang.
   initial begin
      #160000;
      bad_count++;
      stop_test();
   end
endmodule : testbench
`default_nettype wire
